// ---- logic/pixel_transfer_draw_unit.sv ----
// Purpose: pixel move and draw-step execution datapath with apb registers
// Assumes: one 32-bit pixel-memory word per bit address >> 5, read data valid in the mem_ready cycle
// Notes: pixel memory is reached through mem_* ports with a ready handshake
`timescale 1ns/10ps
module pixel_transfer_draw_unit
	import pixel_unit_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pixel memory
	output logic             mem_req,
	output logic             mem_we,
	output logic      [31:0] mem_addr,
	output logic      [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ready,
	// status
	output logic             busy
);
	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_SRDRQ = 6'b000010,
		S_DRDRQ = 6'b000100,
		S_WRRQ  = 6'b001000,
		S_STEP  = 6'b010000,
		S_DONE  = 6'b100000
	} state_type;

	state_type   state_r;
	state_type   state_nxt;
	op_type      op_r;
	logic [31:0] src_op_r;
	logic [31:0] dst_op_r;
	logic [31:0] control_r;
	logic [31:0] pix_width_r;
	logic [31:0] plane_mask_r;
	logic [31:0] src_pitch_r;
	logic [31:0] dst_pitch_r;
	logic [31:0] fg_colour_r;
	logic [31:0] offset_r;
	logic        done_r;
	logic [31:0] pix_r;
	logic [31:0] word_r;
	logic [31:0] new_word;
	logic [31:0] src_bit_addr;
	logic [31:0] dst_bit_addr;
	logic [5:0]  pix_bits;
	logic        wr_acc;
	logic        rd_acc;
	logic        go;
	logic        src_is_reg;
	logic        dst_is_reg;
	logic [31:0] field_mask;
	logic        apb_err;

	// xy to bit address: y * pitch + x * width + offset
	function automatic logic [31:0] xy_to_lin(input logic [31:0] xy, input logic [31:0] pitch,
		input logic [5:0] bits, input logic [31:0] off);
		logic [31:0] y;
		logic [31:0] x;
		y = {16'h0000, xy[31:XY_HALF]};
		x = {16'h0000, xy[XY_HALF-1:0]};
		xy_to_lin = y * pitch + x * {26'h0000000, bits} + off;
	endfunction : xy_to_lin

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == OFF_CMD) || (a == OFF_STATUS) || (a == OFF_SRC_OP)
			|| (a == OFF_DST_OP) || (a == OFF_CONTROL) || (a == OFF_PIX_WIDTH)
			|| (a == OFF_PLANE_MASK) || (a == OFF_SRC_PITCH) || (a == OFF_DST_PITCH)
			|| (a == OFF_FG_COLOUR) || (a == OFF_OFFSET);
	endfunction : mapped

	assign pix_bits   = (pix_width_r[5:0] == 6'h00) ? PW_MAX : pix_width_r[5:0];
	assign field_mask = (pix_bits >= PW_MAX) ? 32'hffff_ffff
		: ((32'h0000_0001 << pix_bits) - 32'h0000_0001);
	assign src_is_reg = (op_r == OP_REG_TO_LIN) || (op_r == OP_REG_TO_XY)
		|| (op_r == OP_DRAW_STEP);
	assign dst_is_reg = (op_r == OP_LIN_TO_REG) || (op_r == OP_XY_TO_REG);
	// pitch factors only enter xy forms
	assign src_bit_addr = (op_r == OP_XY_TO_REG || op_r == OP_XY_TO_XY)
		? xy_to_lin(src_op_r, src_pitch_r, pix_bits, offset_r) : src_op_r;
	assign dst_bit_addr = (op_r == OP_REG_TO_XY || op_r == OP_XY_TO_XY
		|| op_r == OP_DRAW_STEP)
		? xy_to_lin(dst_op_r, dst_pitch_r, pix_bits, offset_r) : dst_op_r;

	assign busy    = (state_r != S_IDLE);
	assign pready  = 1'b1;
	assign apb_err = !mapped(paddr) || (pwrite && busy && paddr != OFF_STATUS);
	assign pslverr = psel && penable && apb_err;
	assign wr_acc  = clk_en && psel && penable && pwrite && !apb_err;
	assign rd_acc  = psel && !penable && !pwrite;
	assign go      = wr_acc && (paddr == OFF_CMD) && pwdata[CMD_GO_BIT];

	pixel_combine u_combine (
		.src_pix    (pix_r),
		.old_word   (word_r),
		.bit_pos    (dst_bit_addr[4:0]),
		.pix_bits   (pix_bits),
		.pp_code    (control_r[CTL_PP_LO +: CTL_PP_W]),
		.transp_en  (control_r[CTL_TRANSP_BIT]),
		.plane_mask (plane_mask_r),
		.new_word   (new_word)
	);

	// register writes; busy blocks operand writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r         <= OP_REG_TO_LIN;
			control_r    <= RST_ZERO;
			pix_width_r  <= RST_PIX_WIDTH;
			plane_mask_r <= RST_ZERO;
			src_pitch_r  <= RST_ZERO;
			dst_pitch_r  <= RST_ZERO;
			fg_colour_r  <= RST_ZERO;
			offset_r     <= RST_ZERO;
		end else if (wr_acc) begin
			unique case (paddr)
				OFF_CMD:        op_r         <= op_type'(pwdata[CMD_OP_LO +: 3]);
				OFF_CONTROL:    control_r    <= pwdata;
				OFF_PIX_WIDTH:  pix_width_r  <= pwdata;
				OFF_PLANE_MASK: plane_mask_r <= pwdata;
				OFF_SRC_PITCH:  src_pitch_r  <= pwdata;
				OFF_DST_PITCH:  dst_pitch_r  <= pwdata;
				OFF_FG_COLOUR:  fg_colour_r  <= pwdata;
				OFF_OFFSET:     offset_r     <= pwdata;
				default:        op_r         <= op_r;
			endcase
		end
	end

	// operand registers: written by software or by the datapath
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_op_r <= RST_ZERO;
			dst_op_r <= RST_ZERO;
		end else if (clk_en) begin
			if (wr_acc && paddr == OFF_SRC_OP) begin
				src_op_r <= pwdata;
			end
			if (wr_acc && paddr == OFF_DST_OP) begin
				dst_op_r <= pwdata;
			end else if (state_r == S_STEP && op_r == OP_DRAW_STEP) begin
				dst_op_r[31:XY_HALF]  <= dst_op_r[31:XY_HALF] + src_op_r[31:XY_HALF];
				dst_op_r[XY_HALF-1:0] <= dst_op_r[XY_HALF-1:0] + src_op_r[XY_HALF-1:0];
			end else if (state_r == S_STEP && dst_is_reg) begin
				dst_op_r <= pix_r & field_mask;
			end
		end
	end

	// read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= RST_ZERO;
		end else if (clk_en && rd_acc) begin
			unique case (paddr)
				OFF_CMD:        prdata <= {29'h0000000, op_r};
				OFF_STATUS:     prdata <= {30'h00000000, done_r, busy};
				OFF_SRC_OP:     prdata <= src_op_r;
				OFF_DST_OP:     prdata <= dst_op_r;
				OFF_CONTROL:    prdata <= control_r;
				OFF_PIX_WIDTH:  prdata <= pix_width_r;
				OFF_PLANE_MASK: prdata <= plane_mask_r;
				OFF_SRC_PITCH:  prdata <= src_pitch_r;
				OFF_DST_PITCH:  prdata <= dst_pitch_r;
				OFF_FG_COLOUR:  prdata <= fg_colour_r;
				OFF_OFFSET:     prdata <= offset_r;
				default:        prdata <= RST_ZERO;
			endcase
		end
	end

	// sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_IDLE:  if (go) begin
				state_nxt = S_SRDRQ;
			end
			S_SRDRQ: if (src_is_reg) begin
				state_nxt = S_DRDRQ;
			end else if (mem_ready) begin
				state_nxt = dst_is_reg ? S_STEP : S_DRDRQ;
			end
			S_DRDRQ: if (mem_ready) begin
				state_nxt = S_WRRQ;
			end
			S_WRRQ:  if (mem_ready) begin
				state_nxt = S_STEP;
			end
			S_STEP:  state_nxt = S_DONE;
			S_DONE:  state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// source pixel and destination word capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_r  <= RST_ZERO;
			word_r <= RST_ZERO;
		end else if (clk_en) begin
			if (state_r == S_SRDRQ) begin
				if (op_r == OP_DRAW_STEP) begin
					pix_r <= fg_colour_r & field_mask;
				end else if (src_is_reg) begin
					pix_r <= src_op_r & field_mask;
				end else if (mem_ready) begin
					pix_r <= (mem_rdata >> src_bit_addr[4:0]) & field_mask;
				end
			end
			if (state_r == S_DRDRQ && mem_ready) begin
				word_r <= mem_rdata;
			end
		end
	end

	// done flag: set on finish, cleared by a new start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
		end else if (clk_en) begin
			if (state_r == S_DONE) begin
				done_r <= 1'b1;
			end else if (go) begin
				done_r <= 1'b0;
			end
		end
	end

	// memory port
	always_comb begin
		mem_req   = 1'b0;
		mem_we    = 1'b0;
		mem_addr  = 32'h0000_0000;
		mem_wdata = new_word;
		if (state_r == S_SRDRQ && !src_is_reg) begin
			mem_req  = 1'b1;
			mem_addr = {5'h00, src_bit_addr[31:5]};
		end else if (state_r == S_DRDRQ) begin
			mem_req  = 1'b1;
			mem_addr = {5'h00, dst_bit_addr[31:5]};
		end else if (state_r == S_WRRQ) begin
			mem_req  = 1'b1;
			mem_we   = 1'b1;
			mem_addr = {5'h00, dst_bit_addr[31:5]};
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	reg_keep_a: assert property (state_r == S_STEP && !dst_is_reg && op_r != OP_DRAW_STEP
		&& !(wr_acc && paddr == OFF_DST_OP) |=> $stable(dst_op_r))
		else $error("operand register changed by register-to-memory move");
	upper_clear_a: assert property (state_r == S_STEP && dst_is_reg && clk_en
		&& !(wr_acc && paddr == OFF_DST_OP) |=> (dst_op_r & ~field_mask) == 32'h0)
		else $error("upper bits not cleared");
	xy_step_a: assert property (state_r == S_STEP && op_r == OP_DRAW_STEP && clk_en
		&& !(wr_acc && paddr == OFF_DST_OP)
		|=> dst_op_r[15:0] == $past(dst_op_r[15:0]) + $past(src_op_r[15:0])
		&& dst_op_r[31:16] == $past(dst_op_r[31:16]) + $past(src_op_r[31:16]))
		else $error("xy advance wrong");
	transp_a: assert property (mem_we && control_r[CTL_TRANSP_BIT]
		&& pix_r == 32'h0 |-> mem_wdata == word_r)
		else $error("transparent pixel modified memory");
	draw_colour_a: assert property (state_r == S_SRDRQ && op_r == OP_DRAW_STEP && clk_en
		|=> pix_r == (fg_colour_r & field_mask))
		else $error("draw colour wrong");
	reg_src_a: assert property (state_r == S_SRDRQ && op_r == OP_REG_TO_LIN && clk_en
		|=> pix_r == (src_op_r & field_mask))
		else $error("register source pixel wrong");
	mask_keep_a: assert property (mem_we |-> (mem_wdata & (plane_mask_r << dst_bit_addr[4:0]))
		== (word_r & (plane_mask_r << dst_bit_addr[4:0])))
		else $error("masked plane altered");
	lin_addr_a: assert property (state_r == S_DRDRQ && op_r == OP_LIN_TO_LIN
		|-> mem_addr == {5'h00, dst_op_r[31:5]})
		else $error("linear address used a pitch factor");
	done_a: assert property (state_r == S_WRRQ && mem_ready && clk_en |-> ##3 done_r)
		else $error("done not raised");

	draw_c: cover property (state_r == S_STEP && op_r == OP_DRAW_STEP);
	xy_move_c: cover property (state_r == S_WRRQ && op_r == OP_XY_TO_XY && mem_ready);
	to_reg_c: cover property (state_r == S_STEP && op_r == OP_XY_TO_REG);
endmodule : pixel_transfer_draw_unit

// ---- logic/pixel_unit_pkg.sv ----
// Purpose: constants for the pixel move / draw-step datapath
// Assumes: 32-bit apb data, word-aligned registers
// Notes: offsets are byte addresses
package pixel_unit_pkg;
	localparam int          DATA_W          = 32;
	localparam int          ADDR_W          = 12;
	// register byte offsets
	localparam logic [11:0] OFF_CMD         = 12'h000;
	localparam logic [11:0] OFF_STATUS      = 12'h004;
	localparam logic [11:0] OFF_SRC_OP      = 12'h008;
	localparam logic [11:0] OFF_DST_OP      = 12'h00c;
	localparam logic [11:0] OFF_CONTROL     = 12'h010;
	localparam logic [11:0] OFF_PIX_WIDTH   = 12'h014;
	localparam logic [11:0] OFF_PLANE_MASK  = 12'h018;
	localparam logic [11:0] OFF_SRC_PITCH   = 12'h01c;
	localparam logic [11:0] OFF_DST_PITCH   = 12'h020;
	localparam logic [11:0] OFF_FG_COLOUR   = 12'h024;
	localparam logic [11:0] OFF_OFFSET      = 12'h028;
	// command field positions
	localparam int          CMD_OP_LO       = 0;
	localparam int          CMD_GO_BIT      = 31;
	// control fields
	localparam int          CTL_TRANSP_BIT  = 5;
	localparam int          CTL_PP_LO       = 10;
	localparam int          CTL_PP_W        = 5;
	// status fields
	localparam int          STAT_BUSY_BIT   = 0;
	localparam int          STAT_DONE_BIT   = 1;
	// reset values
	localparam logic [31:0] RST_PIX_WIDTH   = 32'h0000_0010;
	localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
	// xy layout
	localparam int          XY_HALF         = 16;
	// operation codes
	typedef enum logic [2:0] {
		OP_REG_TO_LIN = 3'h0,
		OP_REG_TO_XY  = 3'h1,
		OP_LIN_TO_REG = 3'h2,
		OP_LIN_TO_LIN = 3'h3,
		OP_XY_TO_REG  = 3'h4,
		OP_XY_TO_XY   = 3'h5,
		OP_DRAW_STEP  = 3'h6
	} op_type;
	// pixel processing codes
	localparam logic [4:0]  PP_REPLACE      = 5'h00;
	localparam logic [4:0]  PP_AND          = 5'h01;
	localparam logic [4:0]  PP_AND_NOT      = 5'h02;
	localparam logic [4:0]  PP_ZERO         = 5'h03;
	localparam logic [4:0]  PP_OR_NOT       = 5'h04;
	localparam logic [4:0]  PP_XNOR         = 5'h05;
	localparam logic [4:0]  PP_NOT_DST      = 5'h06;
	localparam logic [4:0]  PP_NOR          = 5'h07;
	localparam logic [4:0]  PP_OR           = 5'h08;
	localparam logic [4:0]  PP_XOR          = 5'h0a;
	localparam logic [4:0]  PP_ADD          = 5'h10;
	localparam logic [4:0]  PP_SUB          = 5'h12;
	localparam logic [4:0]  PP_MAX          = 5'h15;
	localparam logic [4:0]  PP_MIN          = 5'h17;
	// pixel widths as bit counts
	localparam logic [5:0]  PW_MAX          = 6'h20;
endpackage : pixel_unit_pkg

// ---- logic/pixel_combine.sv ----
// Purpose: combine a source pixel with a destination memory word
// Assumes: widths 1,2,4,8,16 or 32 bits; pixel aligned in the word
// Notes: pure combinational
`timescale 1ns/10ps
module pixel_combine
	import pixel_unit_pkg::*;
(
	// operands
	input  wire logic [31:0] src_pix,
	input  wire logic [31:0] old_word,
	input  wire logic [4:0]  bit_pos,
	input  wire logic [5:0]  pix_bits,
	// settings
	input  wire logic [4:0]  pp_code,
	input  wire logic        transp_en,
	input  wire logic [31:0] plane_mask,
	// result
	output logic      [31:0] new_word
);
	logic [31:0] field_mask;
	logic [31:0] dst_pix;
	logic [31:0] res_pix;
	logic [31:0] res_word;
	logic [31:0] src_m;

	always_comb begin
		field_mask = (pix_bits >= PW_MAX) ? 32'hffff_ffff
			: ((32'h0000_0001 << pix_bits) - 32'h0000_0001);
		src_m      = src_pix & field_mask;
		dst_pix    = (old_word >> bit_pos) & field_mask;
		unique case (pp_code)
			PP_AND:     res_pix = src_m & dst_pix;
			PP_AND_NOT: res_pix = src_m & ~dst_pix;
			PP_ZERO:    res_pix = 32'h0000_0000;
			PP_OR_NOT:  res_pix = src_m | ~dst_pix;
			PP_XNOR:    res_pix = ~(src_m ^ dst_pix);
			PP_NOT_DST: res_pix = ~dst_pix;
			PP_NOR:     res_pix = ~(src_m | dst_pix);
			PP_OR:      res_pix = src_m | dst_pix;
			PP_XOR:     res_pix = src_m ^ dst_pix;
			PP_ADD:     res_pix = src_m + dst_pix;
			PP_SUB:     res_pix = dst_pix - src_m;
			PP_MAX:     res_pix = (src_m > dst_pix) ? src_m : dst_pix;
			PP_MIN:     res_pix = (src_m < dst_pix) ? src_m : dst_pix;
			default:    res_pix = src_m;
		endcase
		res_pix  = res_pix & field_mask;
		// masked planes keep their old value
		res_word = (old_word & ~(field_mask << bit_pos))
			| ((res_pix << bit_pos) & ~(plane_mask << bit_pos));
		res_word = res_word
			| (old_word & (plane_mask << bit_pos) & (field_mask << bit_pos));
		if (transp_en && (src_m == 32'h0000_0000)) begin
			new_word = old_word;
		end else begin
			new_word = res_word;
		end
	end
endmodule : pixel_combine

// ---- tb/pixel_mem_model.sv ----
// Purpose: behavioural pixel memory on the far side of the mem_* ports
// Assumes: word address in mem_addr, 256 words kept, answer in the ready cycle
// Notes: slow inserts three wait cycles; idle read data shows the inverse of the last word
`timescale 1ns/10ps
module pixel_mem_model (
	// clock
	input  wire logic        pclk,
	// request
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	// answer
	output logic      [31:0] mem_rdata,
	output logic             mem_ready,
	// pacing
	input  wire logic        slow
);
	logic [31:0] mem [0:255];
	logic [31:0] last_r;
	logic [1:0]  cnt_r;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = {4{i[7:0]}} ^ 32'h5a3c_a5c3;
		end
		last_r = 32'h0;
		cnt_r = 2'h0;
	end
	// ready after a wait when slow
	assign mem_ready = mem_req && (!slow || cnt_r == 2'h3);
	assign mem_rdata = (mem_req && !mem_we && mem_ready) ? mem[mem_addr[7:0]] : ~last_r;
	always @(posedge pclk) begin
		cnt_r <= mem_req ? cnt_r + 2'h1 : 2'h0;
		if (mem_req && mem_ready) begin
			if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
			else last_r <= mem[mem_addr[7:0]];
		end
	end
endmodule : pixel_mem_model

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the pixel move / draw-step unit
// Assumes: apb master tasks, memory model partner, seed 50049
// Notes: apb read expectations are queued and checked by a monitor
`timescale 1ns/10ps
module tb;
	import pixel_unit_pkg::*;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic        mem_req, mem_we, mem_ready, busy, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] q[$];
	logic [31:0] da, sa, sv, sp, pm, ex, sxy, dxy, sb, db;
	logic [4:0]  codes [14] = '{PP_REPLACE, PP_AND, PP_AND_NOT, PP_ZERO, PP_OR_NOT, PP_XNOR,
		PP_NOT_DST, PP_NOR, PP_OR, PP_XOR, PP_ADD, PP_SUB, PP_MAX, PP_MIN};
	int          n_mismatch, cmp_count, cyc, w;
	logic        tr;
	op_type      op;

	pixel_transfer_draw_unit u_pixel_transfer_draw_unit (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ready(mem_ready), .busy(busy));
	pixel_mem_model u_pixel_mem_model (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ready(mem_ready), .slow(slow));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		if (!wr && !e) q.push_back(d);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pslverr", {31'h0, pslverr}, {31'h0, e});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, exp, 1'b0);
	endtask : rd

	task go(input op_type o, input logic e);
		int n;
		wr(OFF_CMD, {1'b1, 28'h0, o});
		if (e) apb(1'b1, OFF_OFFSET, 32'h0000_1234, 1'b1);
		n = 0;
		@(posedge pclk);
		while (busy !== 1'b0 && n < 500) begin
			@(posedge pclk);
			n++;
		end
		if (n == 500) chk("busy", {31'h0, busy}, 32'h0);
	endtask : go

	function automatic logic [31:0] mw(input logic [31:0] b);
		return u_pixel_mem_model.mem[b[12:5]];
	endfunction : mw

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] src,
		input int pos, input int wd, input logic [4:0] pp, input logic t, input logic [31:0] msk);
		logic [31:0] m, s, d, r, fm;
		m = (32'h1 << wd) - 32'h1;
		s = src & m;
		d = (old >> pos) & m;
		case (pp)
			PP_AND: r = s & d;
			PP_AND_NOT: r = s & ~d;
			PP_OR_NOT: r = s | ~d;
			PP_ZERO: r = 32'h0;
			PP_XNOR: r = ~(s ^ d);
			PP_NOT_DST: r = ~d;
			PP_NOR: r = ~(s | d);
			PP_OR: r = s | d;
			PP_XOR: r = s ^ d;
			PP_ADD: r = s + d;
			PP_SUB: r = d - s;
			PP_MAX: r = (s > d) ? s : d;
			PP_MIN: r = (s < d) ? s : d;
			default: r = s;
		endcase
		if (t && s == 32'h0) return old;
		fm = (m << pos) & ~(msk << pos);
		return (old & ~fm) | ((r << pos) & fm);
	endfunction : merge

	function automatic logic [31:0] xyb(input logic [31:0] xy, input logic [31:0] p);
		return xy[31:16] * p + xy[15:0] * 32'h4 + 32'h200;
	endfunction : xyb

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && !pslverr && q.size() > 0)
			chk("prdata", prdata, q.pop_front());
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			finish_test;
		end
	end

	initial begin
		{psel, penable, pwrite, presetn, slow} = 5'h0;
		{clk_en, paddr, pwdata} = {1'b1, 12'h0, 32'h0};
		void'($urandom(50049));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_PIX_WIDTH, RST_PIX_WIDTH);
		apb(1'b0, 12'h100, 32'h0, 1'b1);
		for (int i = 0; i < 28; i++) begin
			w = (i % 2) ? 8 : 4;
			tr = i[2];
			op = (i % 4 < 2) ? OP_REG_TO_LIN : OP_LIN_TO_LIN;
			da = ($urandom_range(0, 63) << 5) + w * $urandom_range(0, 32 / w - 1);
			sa = ($urandom_range(64, 127) << 5) + w * $urandom_range(0, 32 / w - 1);
			sv = (i % 8 == 4) ? 32'h0 : $urandom;
			pm = $urandom;
			slow <= (i >= 14);
			wr(OFF_CONTROL, ({27'h0, codes[i % 14]} << CTL_PP_LO) | ({31'h0, tr} << CTL_TRANSP_BIT));
			wr(OFF_PIX_WIDTH, w);
			wr(OFF_PLANE_MASK, pm);
			wr(OFF_SRC_PITCH, $urandom);
			wr(OFF_DST_PITCH, $urandom);
			wr(OFF_SRC_OP, (op == OP_REG_TO_LIN) ? sv : sa);
			wr(OFF_DST_OP, da);
			sp = (op == OP_REG_TO_LIN) ? sv : (mw(sa) >> sa[4:0]);
			ex = merge(mw(da), sp, da[4:0], w, codes[i % 14], tr, pm);
			go(op, i >= 14);
			chk("linear word", mw(da), ex);
			rd(OFF_SRC_OP, (op == OP_REG_TO_LIN) ? sv : sa);
			rd(OFF_DST_OP, da);
		end
		rd(OFF_OFFSET, 32'h0);
		slow <= 1'b0;
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_PLANE_MASK, 32'h0);
		wr(OFF_PIX_WIDTH, 32'h4);
		wr(OFF_OFFSET, 32'h200);
		wr(OFF_SRC_PITCH, 32'h80);
		wr(OFF_DST_PITCH, 32'h100);
		wr(OFF_SRC_OP, sa);
		wr(OFF_DST_OP, 32'hffff_ffff);
		go(OP_LIN_TO_REG, 1'b0);
		rd(OFF_DST_OP, (mw(sa) >> sa[4:0]) & 32'hf);
		sxy = {16'($urandom_range(0, 3)), 16'($urandom_range(0, 7))};
		dxy = {16'($urandom_range(0, 3)), 16'($urandom_range(0, 7))};
		sb = xyb(sxy, 32'h80);
		db = xyb(dxy, 32'h100);
		sv = $urandom;
		wr(OFF_SRC_OP, sv);
		wr(OFF_DST_OP, dxy);
		ex = merge(mw(db), sv, db[4:0], 4, PP_REPLACE, 1'b0, 32'h0);
		go(OP_REG_TO_XY, 1'b0);
		chk("xy word", mw(db), ex);
		wr(OFF_SRC_OP, sxy);
		wr(OFF_DST_OP, 32'hffff_ffff);
		go(OP_XY_TO_REG, 1'b0);
		rd(OFF_DST_OP, (mw(sb) >> sb[4:0]) & 32'hf);
		wr(OFF_DST_OP, dxy);
		ex = merge(mw(db), mw(sb) >> sb[4:0], db[4:0], 4, PP_REPLACE, 1'b0, 32'h0);
		go(OP_XY_TO_XY, 1'b0);
		chk("xy copy", mw(db), ex);
		sv = $urandom;
		db = xyb(32'h0001_0002, 32'h100);
		wr(OFF_FG_COLOUR, sv);
		wr(OFF_SRC_OP, 32'h0001_fffe);
		wr(OFF_DST_OP, 32'h0001_0002);
		ex = merge(mw(db), sv, db[4:0], 4, PP_REPLACE, 1'b0, 32'h0);
		go(OP_DRAW_STEP, 1'b0);
		chk("draw word", mw(db), ex);
		rd(OFF_DST_OP, 32'h0002_0000);
		clk_en <= 1'b0;
		wr(OFF_FG_COLOUR, ~sv);
		clk_en <= 1'b1;
		rd(OFF_FG_COLOUR, sv);
		repeat (4) @(posedge pclk);
		finish_test;
	end
endmodule : tb
